// >>> rtl/sci_pkg.sv
// constants and types shared by the serial control block and its rate generator
// assumes a 32-bit classic wishbone slave with byte-wide registers in the low lane
package sci_pkg;

  // register indexes; byte address is four times the index
  localparam logic [7:0] STATUS_IDX = 8'h50;
  localparam logic [7:0] DATA_IDX   = 8'h51;
  localparam logic [7:0] BAUD_IDX   = 8'h52;
  localparam logic [7:0] FRAME_IDX  = 8'h53;
  localparam logic [7:0] IRQEN_IDX  = 8'h54;
  localparam logic [7:0] EXT_RX_IDX = 8'h55;
  localparam logic [7:0] EXT_TX_IDX = 8'h57;

  // frame_parity_control fields
  localparam int RX_NINTH_POS = 7;
  localparam int TX_NINTH_POS = 6;
  localparam int PD_POS       = 5;
  localparam int M9_POS       = 4;
  localparam int WAKE_POS     = 3;
  localparam int PCE_POS      = 2;
  localparam int PS_POS       = 1;
  localparam int PIE_POS      = 0;

  // irq_enable_control fields
  localparam int TIE_POS  = 7;
  localparam int TX_DONE_IRQ_ENABLE_POS = 6;
  localparam int RIE_POS  = 5;
  localparam int IDLE_IRQ_ENABLE_POS = 4;
  localparam int TE_POS   = 3;
  localparam int RE_POS   = 2;
  localparam int RWU_POS  = 1;
  localparam int SBK_POS  = 0;

  // status fields
  localparam int TX_EMPTY_FLAG_POS = 7;
  localparam int TC_POS   = 6;
  localparam int RX_FULL_FLAG_POS = 5;
  localparam int IDLE_POS = 4;
  localparam int OVR_POS  = 3;
  localparam int FE_POS   = 1;
  localparam int PE_POS   = 0;

  // baud_rate_divisors fields (low bit of each)
  localparam int SCP_POS = 6;
  localparam int SCT_POS = 3;
  localparam int SCR_POS = 0;

  // reset values
  localparam logic [7:0] FRAME_RST  = 8'h00;
  localparam logic [7:0] IRQEN_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST   = 8'h00;
  localparam logic [7:0] EXT_RST    = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'hc0;

  // first division factors for codes 00, 01, 10, 11
  localparam logic [3:0] PR_F0 = 4'h1;
  localparam logic [3:0] PR_F1 = 4'h3;
  localparam logic [3:0] PR_F2 = 4'h4;
  localparam logic [3:0] PR_F3 = 4'hd;

  // timing counts in rate ticks
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;  // sixteen samples per bit
  localparam logic [3:0] START_MID       = 4'h7;  // sample at mid start bit
  localparam logic [3:0] FRAME_LEN8      = 4'ha;  // start, 8 data, stop
  localparam logic [3:0] FRAME_LEN9      = 4'hb;  // start, 9 data, stop

  typedef enum logic [2:0] {TX_OFF, TX_DELAY, TX_IDLE, TX_DATA, TX_PRE, TX_BRK} tx_state_type;
  typedef enum logic [2:0] {RX_OFF, RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;

endpackage

// >>> rtl/baud_rate_gen.sv
// coarse prescaler, power-of-two divider and optional extended divider
// assumes one clock; run low holds the counters cleared (power-down)
`timescale 1ns/1ps
`default_nettype none
module baud_rate_gen
  import sci_pkg::*;
#(
  parameter int unsigned DIV_W = 20
)(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [1:0] pr_code,
  input  wire logic [2:0] div_code,
  input  wire logic [7:0] ext_div,
  output logic            sample_tick,
  output logic            bit_tick
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic [3:0]       sub;
    logic             sample;
    logic             bitt;
  } gen_type;

  gen_type          gen_reg;
  gen_type          gen_next;
  logic [DIV_W-1:0] pr_factor;
  logic [DIV_W-1:0] divisor;

  // total divide per sample tick; a zero extended value leaves that stage out
  always_comb
  begin
    case (pr_code)
      2'b00:   pr_factor = DIV_W'(PR_F0);
      2'b01:   pr_factor = DIV_W'(PR_F1);
      2'b10:   pr_factor = DIV_W'(PR_F2);
      default: pr_factor = DIV_W'(PR_F3);
    endcase
    divisor = pr_factor * (DIV_W'(1) << div_code)
              * ((ext_div == 8'h00) ? DIV_W'(1) : DIV_W'(ext_div));
  end

  // sample tick every divisor clocks, bit tick every sixteenth sample
  always_comb
  begin
    gen_next        = gen_reg;
    gen_next.sample = 1'b0;
    gen_next.bitt   = 1'b0;
    if (!run)
    begin
      gen_next.cnt = '0;
      gen_next.sub = 4'h0;
    end
    else if (gen_reg.cnt >= divisor - DIV_W'(1))
    begin
      gen_next.cnt    = '0;
      gen_next.sample = 1'b1;
      gen_next.sub    = gen_reg.sub + 4'h1;
      gen_next.bitt   = (gen_reg.sub == OVERSAMPLE_LAST);
    end
    else
      gen_next.cnt = gen_reg.cnt + DIV_W'(1);
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      gen_reg <= '0;
    else if (ce)
      gen_reg <= gen_next;
  end

  assign sample_tick = gen_reg.sample;
  assign bit_tick    = gen_reg.bitt;
endmodule
`default_nettype wire

// >>> rtl/async_serial_control_baud.sv
// asynchronous serial transceiver: control, data buffer and baud configuration
// assumes a classic wishbone master on sys_clk and an asynchronous rx pin
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module async_serial_control_baud
  import sci_pkg::*;
#(
  parameter int unsigned DIV_W = 20
)(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        rx_pin,
  output logic             tx_pin_out,
  output logic             tx_pin_oe,
  output logic             serial_irq
);
  import sci_pkg::*;

  typedef struct packed {
    logic [7:0]   cr1;
    logic [7:0]   cr2;
    logic [7:0]   brr;
    logic [7:0]   ext_rx_divisor;
    logic [7:0]   ext_tx_divisor;
    logic [7:0]   sr;
    logic         seen;
    logic [7:0]   tx_hold;
    logic [7:0]   rx_hold;
    logic         ack;
    logic [7:0]   dat;
    tx_state_type tx_state;
    logic [10:0]  tx_shift;
    logic [3:0]   tx_cnt;
    logic         tx_out;
    logic         tx_oe;
    logic         te_ever;
    logic         te_prev;
    logic         sbk_prev;
    logic         pre_pend;
    logic         brk_pend;
    logic         rx_s1;
    logic         rx_s2;
    rx_state_type rx_state;
    logic [3:0]   rx_scnt;
    logic [3:0]   rx_bcnt;
    logic [8:0]   rx_shift;
    logic [7:0]   idle_cnt;
    logic         idle_armed;
    logic         rx_m9;
    logic         rx_pce;
    logic         rx_ps;
    logic         irq;
  } state_type;

  state_type   s_reg;
  state_type   s_next;
  logic        te;
  logic        re;
  logic        send_break_ctl;
  logic        m9;
  logic        pd_active;
  logic        tx_tick;
  logic        rx_tick;
  logic [3:0]  flen;

  assign te   = s_reg.cr2[TE_POS];
  assign re   = s_reg.cr2[RE_POS];
  assign send_break_ctl  = s_reg.cr2[SBK_POS];
  assign m9   = s_reg.cr1[M9_POS];
  assign flen = m9 ? FRAME_LEN9 : FRAME_LEN8;

  // prescalers stop only between bytes so a frame in flight completes
  assign pd_active = s_reg.cr1[PD_POS]
                     && !(s_reg.tx_state inside {TX_DATA, TX_PRE, TX_BRK})
                     && !(s_reg.rx_state inside {RX_START, RX_DATA, RX_STOP});

  // transmit and receive rate generators share the coarse prescale code
  baud_rate_gen #(.DIV_W(DIV_W)) tx_gen (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .ce          (ce),
    .run         (!pd_active),
    .pr_code     (s_reg.brr[SCP_POS+1:SCP_POS]),
    .div_code    (s_reg.brr[SCT_POS+2:SCT_POS]),
    .ext_div     (s_reg.ext_tx_divisor),
    .sample_tick (),
    .bit_tick    (tx_tick)
  );

  baud_rate_gen #(.DIV_W(DIV_W)) rx_gen (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .ce          (ce),
    .run         (!pd_active),
    .pr_code     (s_reg.brr[SCP_POS+1:SCP_POS]),
    .div_code    (s_reg.brr[SCR_POS+2:SCR_POS]),
    .ext_div     (s_reg.ext_rx_divisor),
    .sample_tick (rx_tick),
    .bit_tick    ()
  );

  // outgoing frame, lsb first, parity computed at load so it binds one byte
  function automatic logic [10:0] data_frame(input logic [7:0] d, input logic b8,
                                             input logic nine, input logic parity_enable,
                                             input logic ps);
    logic p9;
    logic p8;
    p9 = (^d) ^ ps;
    p8 = (^d[6:0]) ^ ps;
    if (nine)
      data_frame = {1'b1, (parity_enable ? p9 : b8), d, 1'b0};
    else
      data_frame = {2'b11, (parity_enable ? p8 : d[7]), d[6:0], 1'b0};
  endfunction

  // one process computes the whole next state
  always_comb
  begin
    logic        req;
    logic        wr;
    logic        rd;
    logic [7:0]  idx;
    logic        pick;
    logic [10:0] fr;
    logic [7:0]  rxd;
    logic [8:0]  wbits;
    logic        perr;
    logic        deliver;
    req     = cyc_i & stb_i & ~s_reg.ack;
    wr      = req & we_i & sel_i[0];
    rd      = req & ~we_i;
    idx     = adr_i[9:2];
    pick    = 1'b0;
    fr      = '1;
    rxd     = 8'h00;
    wbits   = 9'h000;
    perr    = 1'b0;
    deliver = 1'b0;
    s_next  = s_reg;

    // bus slave: one wait state, unmapped reads return zero
    s_next.ack      = req;
    s_next.rx_s1    = rx_pin;
    s_next.rx_s2    = s_reg.rx_s1;
    s_next.te_prev  = te;
    s_next.sbk_prev = send_break_ctl;
    if (rd)
    begin
      case (idx)
        STATUS_IDX: s_next.dat = s_reg.sr;
        DATA_IDX:   s_next.dat = s_reg.rx_hold;
        BAUD_IDX:   s_next.dat = s_reg.brr;
        FRAME_IDX:  s_next.dat = s_reg.cr1;
        IRQEN_IDX:  s_next.dat = s_reg.cr2;
        EXT_RX_IDX: s_next.dat = s_reg.ext_rx_divisor;
        EXT_TX_IDX: s_next.dat = s_reg.ext_tx_divisor;
        default:    s_next.dat = 8'h00;
      endcase
    end
    if (wr)
    begin
      case (idx)
        DATA_IDX:   s_next.tx_hold = dat_i[7:0];
        BAUD_IDX:   s_next.brr = dat_i[7:0];
        FRAME_IDX:  s_next.cr1 = {s_reg.cr1[RX_NINTH_POS], dat_i[6:0]};
        IRQEN_IDX:  s_next.cr2 = dat_i[7:0];
        EXT_RX_IDX: s_next.ext_rx_divisor = dat_i[7:0];
        EXT_TX_IDX: s_next.ext_tx_divisor = dat_i[7:0];
        default:    s_next.dat = s_reg.dat;
      endcase
    end

    // flag clearing: status access arms, next data access clears
    if (req && idx == STATUS_IDX)
      s_next.seen = 1'b1;
    else if (req && idx == DATA_IDX && s_reg.seen)
    begin
      s_next.seen = 1'b0;
      if (we_i)
      begin
        s_next.sr[TX_EMPTY_FLAG_POS] = 1'b0;
        s_next.sr[TC_POS]   = 1'b0;
      end
      else
      begin
        s_next.sr[RX_FULL_FLAG_POS] = 1'b0;
        s_next.sr[IDLE_POS] = 1'b0;
        s_next.sr[OVR_POS]  = 1'b0;
        s_next.sr[FE_POS]   = 1'b0;
        s_next.sr[PE_POS]   = 1'b0;
      end
    end

    // transmitter; te low mid-frame arms a preamble, sent only if te returns before that frame ends
    if (te)
      s_next.te_ever = 1'b1;
    if (s_reg.te_prev && !te && s_reg.tx_state inside {TX_DATA, TX_PRE, TX_BRK})
      s_next.pre_pend = 1'b1;
    if (send_break_ctl && !s_reg.sbk_prev)
      s_next.brk_pend = 1'b1;
    case (s_reg.tx_state)
      TX_OFF:
      begin
        s_next.tx_out = 1'b1;
        if (te)
        begin
          s_next.tx_state = TX_DELAY;
          s_next.tx_cnt   = 4'h1;
        end
      end
      TX_DELAY:
      begin
        // line held idle for at least one full bit before the first frame
        if (!te)
          s_next.tx_state = TX_OFF;
        else if (tx_tick)
        begin
          if (s_reg.tx_cnt == 4'h0)
            s_next.tx_state = TX_IDLE;
          else
            s_next.tx_cnt = s_reg.tx_cnt - 4'h1;
        end
      end
      TX_IDLE:
      begin
        s_next.tx_out = 1'b1;
        pick = tx_tick;
      end
      TX_DATA, TX_PRE, TX_BRK:
      begin
        if (tx_tick)
        begin
          if (s_reg.tx_cnt == 4'h0)
          begin
            if (s_reg.tx_state == TX_DATA)
              s_next.sr[TC_POS] = 1'b1;
            pick = 1'b1;
          end
          else
          begin
            s_next.tx_out   = s_reg.tx_shift[0];
            s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
            s_next.tx_cnt   = s_reg.tx_cnt - 4'h1;
          end
        end
      end
      default: s_next.tx_state = TX_OFF;
    endcase

    // next frame choice: disable, then preamble, then break, then data
    if (pick)
    begin
      s_next.tx_state = TX_IDLE;
      s_next.tx_out   = 1'b1;
      if (!te)
      begin
        s_next.tx_state = TX_OFF;
        s_next.pre_pend = 1'b0;
      end
      else if (s_reg.pre_pend)
      begin
        s_next.tx_state = TX_PRE;
        s_next.pre_pend = 1'b0;
        fr = '1;
      end
      else if (s_reg.brk_pend || send_break_ctl)
      begin
        s_next.tx_state = TX_BRK;
        s_next.brk_pend = 1'b0;
        fr = '0;
      end
      else if (!s_reg.sr[TX_EMPTY_FLAG_POS] && !s_reg.cr1[PD_POS])
      begin
        s_next.tx_state     = TX_DATA;
        s_next.sr[TX_EMPTY_FLAG_POS] = 1'b1;
        fr = data_frame(s_reg.tx_hold, s_reg.cr1[TX_NINTH_POS], m9,
                        s_reg.cr1[PCE_POS], s_reg.cr1[PS_POS]);
      end
      if (s_next.tx_state inside {TX_DATA, TX_PRE, TX_BRK})
      begin
        s_next.tx_out   = fr[0];
        s_next.tx_shift = {1'b1, fr[10:1]};
        s_next.tx_cnt   = flen - 4'h1;
      end
    end
    s_next.tx_oe = te | (re & s_reg.te_ever);

    // receiver, run off the sixteen-times sample tick
    wbits = s_reg.rx_m9 ? s_reg.rx_shift : {1'b0, s_reg.rx_shift[8:1]};
    rxd   = s_reg.rx_m9 ? s_reg.rx_shift[7:0] : s_reg.rx_shift[8:1];
    perr  = s_reg.rx_pce && ((^wbits) != s_reg.rx_ps);
    if (!re)
      s_next.rx_state = RX_OFF;
    else if (rx_tick)
    begin
      case (s_reg.rx_state)
        RX_OFF:
        begin
          s_next.rx_state = RX_IDLE;
          s_next.idle_cnt = 8'h00;
        end
        RX_IDLE:
        begin
          if (!s_reg.rx_s2)
          begin
            s_next.rx_state = RX_START;
            s_next.rx_scnt  = 4'h0;
            s_next.rx_m9    = m9;
            s_next.rx_pce   = s_reg.cr1[PCE_POS];
            s_next.rx_ps    = s_reg.cr1[PS_POS];
          end
          else if (s_reg.idle_cnt == {flen, 4'h0})
          begin
            // idle line detected once per received word
            s_next.idle_cnt = s_reg.idle_cnt + 8'h01;
            if (s_reg.idle_armed)
            begin
              s_next.idle_armed = 1'b0;
              if (s_reg.cr2[RWU_POS])
              begin
                if (!s_reg.cr1[WAKE_POS])
                  s_next.cr2[RWU_POS] = 1'b0;
              end
              else
                s_next.sr[IDLE_POS] = 1'b1;
            end
          end
          else if (s_reg.idle_cnt < {flen, 4'h0})
            s_next.idle_cnt = s_reg.idle_cnt + 8'h01;
        end
        RX_START:
        begin
          s_next.rx_scnt = s_reg.rx_scnt + 4'h1;
          if (s_reg.rx_scnt == START_MID)
          begin
            s_next.rx_scnt  = 4'h0;
            s_next.rx_bcnt  = 4'h0;
            s_next.rx_state = s_reg.rx_s2 ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          s_next.rx_scnt = s_reg.rx_scnt + 4'h1;
          if (s_reg.rx_scnt == OVERSAMPLE_LAST)
          begin
            s_next.rx_shift = {s_reg.rx_s2, s_reg.rx_shift[8:1]};
            s_next.rx_bcnt  = s_reg.rx_bcnt + 4'h1;
            if (s_reg.rx_bcnt == (s_reg.rx_m9 ? 4'h8 : 4'h7))
              s_next.rx_state = RX_STOP;
          end
        end
        RX_STOP:
        begin
          s_next.rx_scnt = s_reg.rx_scnt + 4'h1;
          if (s_reg.rx_scnt == OVERSAMPLE_LAST)
          begin
            s_next.rx_state = RX_IDLE;
            s_next.idle_cnt = 8'h00;
            deliver = 1'b1;
            // address mark: top data bit set ends mute, word is kept
            if (s_reg.cr2[RWU_POS])
            begin
              if (s_reg.cr1[WAKE_POS] && s_reg.rx_shift[8])
                s_next.cr2[RWU_POS] = 1'b0;
              else
                deliver = 1'b0;
            end
          end
        end
        default: s_next.rx_state = RX_OFF;
      endcase
    end
    if (deliver)
    begin
      if (s_reg.sr[RX_FULL_FLAG_POS])
        s_next.sr[OVR_POS] = 1'b1;  // holding kept, new word lost
      else
      begin
        s_next.rx_hold            = rxd;
        s_next.cr1[RX_NINTH_POS]  = s_reg.rx_m9 & s_reg.rx_shift[8];
        s_next.sr[RX_FULL_FLAG_POS]       = 1'b1;
        s_next.sr[FE_POS]         = ~s_reg.rx_s2;
        s_next.sr[PE_POS]         = perr;
        s_next.idle_armed         = 1'b1;
      end
    end

    // single serial interrupt from flags and their enables
    s_next.irq = (s_reg.sr[TX_EMPTY_FLAG_POS] & s_reg.cr2[TIE_POS])
               | (s_reg.sr[TC_POS] & s_reg.cr2[TX_DONE_IRQ_ENABLE_POS])
               | ((s_reg.sr[OVR_POS] | s_reg.sr[RX_FULL_FLAG_POS]) & s_reg.cr2[RIE_POS])
               | (s_reg.sr[IDLE_POS] & s_reg.cr2[IDLE_IRQ_ENABLE_POS])
               | (s_reg.sr[PE_POS] & s_reg.cr1[PIE_POS]);
  end

  // all state advances only with the clock enable high
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      s_reg          <= '0;
      s_reg.cr1      <= FRAME_RST;
      s_reg.cr2      <= IRQEN_RST;
      s_reg.brr      <= BAUD_RST;
      s_reg.ext_rx_divisor     <= EXT_RST;
      s_reg.ext_tx_divisor     <= EXT_RST;
      s_reg.sr       <= STATUS_RST;
      s_reg.tx_state <= TX_OFF;
      s_reg.rx_state <= RX_OFF;
      s_reg.tx_out   <= 1'b1;
      s_reg.tx_shift <= '1;
      s_reg.rx_s1    <= 1'b1;
      s_reg.rx_s2    <= 1'b1;
    end
    else if (ce)
      s_reg <= s_next;
  end

  assign dat_o      = {24'h000000, s_reg.dat};
  assign ack_o      = s_reg.ack;
  assign tx_pin_out = s_reg.tx_out;
  assign tx_pin_oe  = s_reg.tx_oe;
  assign serial_irq = s_reg.irq;
endmodule
`default_nettype wire

// >>> tb/sci_sva.sv
// port checker for the serial control block
// assumes one clock domain and the register map of sci_pkg
`timescale 1ns/1ps
`default_nettype none
module sci_sva
  import sci_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [9:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        rx_pin,
  input wire logic        tx_pin_out,
  input wire logic        tx_pin_oe,
  input wire logic        serial_irq
);
  logic       te_seen_reg;
  logic       en_seen_reg;
  logic [7:0] hi_cnt_reg;
  wire logic  wr_take = cyc_i && stb_i && !ack_o && ce && we_i && sel_i[0];
  wire logic  to_irqen = adr_i[9:2] == IRQEN_IDX;

  // remember enables at the edge a write is taken; count high cycles of the tx line
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      te_seen_reg <= 1'b0;
      en_seen_reg <= 1'b0;
      hi_cnt_reg  <= 8'h00;
    end
    else
    begin
      if (wr_take && to_irqen && dat_i[TE_POS])
        te_seen_reg <= 1'b1;
      if (wr_take && (to_irqen && |dat_i[7:4] || adr_i[9:2] == FRAME_IDX && dat_i[PIE_POS]))
        en_seen_reg <= 1'b1;
      hi_cnt_reg <= !tx_pin_out ? 8'h00 : hi_cnt_reg + {7'h00, hi_cnt_reg != 8'hff};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_req; cyc_i && stb_i && !ack_o && ce; endsequence
  sequence s_hole_rd; s_req ##0 !we_i && adr_i[9:2] == 8'h56; endsequence

  property p_ack_given; s_req |=> ack_o; endproperty
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
  property p_upper_zero; dat_o[31:8] == 24'h000000; endproperty
  property p_hole_zero; s_hole_rd |=> dat_o == 32'h00000000; endproperty
  property p_pin_kept; !te_seen_reg |-> !tx_pin_oe; endproperty
  property p_irq_quiet; !en_seen_reg |-> !serial_irq; endproperty
  property p_bit_gap; $fell(tx_pin_out) |-> hi_cnt_reg >= 8'h0f; endproperty

  a_ack_given: assert property (p_ack_given) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read lanes set");
  a_hole_zero: assert property (p_hole_zero) else $error("unmapped read not zero");
  a_pin_kept: assert property (p_pin_kept) else $error("tx pin driven early");
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq with no enable");
  a_bit_gap: assert property (p_bit_gap) else $error("tx low before a bit time");
endmodule

bind async_serial_control_baud sci_sva chk_u (.sys_clk(sys_clk), .reset(reset), .ce(ce),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .rx_pin(rx_pin), .tx_pin_out(tx_pin_out),
  .tx_pin_oe(tx_pin_oe), .serial_irq(serial_irq));
`default_nettype wire

// >>> tb/serial_node.sv
// behavioural remote serial node: drives the device rx line, decodes its tx line
// assumes the bench gives bit time in clocks and data bit count; line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module serial_node
(
  input  wire logic        sys_clk,
  input  wire logic        line_in,
  input  wire logic [15:0] bit_clks,
  input  wire logic [3:0]  data_bits,
  output logic             line_out,
  output logic [8:0]       got,
  output int               got_count
);
  int         k;
  logic [8:0] w;
  initial line_out = 1'b1;
  initial got_count = 0;

  // one frame lsb first: start low, data, stop high
  task automatic send(input logic [8:0] v);
    int i;
    @(posedge sys_clk);
    line_out <= 1'b0;
    repeat (bit_clks) @(posedge sys_clk);
    for (i = 0; i < data_bits; i++)
    begin
      line_out <= v[i];
      repeat (bit_clks) @(posedge sys_clk);
    end
    line_out <= 1'b1;
    repeat (bit_clks) @(posedge sys_clk);
  endtask

  // decode at mid bit; stop level is not judged so a break reads as zero data
  always
  begin
    @(negedge line_in);
    repeat (bit_clks / 2) @(posedge sys_clk);
    w = 9'h000;
    for (k = 0; k < data_bits; k++)
    begin
      repeat (bit_clks) @(posedge sys_clk);
      w[k] = line_in;
    end
    got = w;
    got_count++;
    wait (line_in === 1'b1);
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the serial control block
// assumes sci_pkg, the design, the bound checker and serial_node are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sci_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] dat_o;
  logic        ack_o, rx_pin, tx_pin_out, tx_pin_oe, serial_irq;
  logic [15:0] bit_clks = 16'h0010;
  logic [3:0]  nbits = 4'h8;
  logic [8:0]  got, w;
  logic [7:0]  q, d, e;
  logic [2:0]  f, t;
  int          got_count, i, n, bt;
  int          err_count = 0;
  int          num_checks = 0;
  int          pr_tab [4] = '{1, 3, 4, 13};
  logic [2:0]  f_tab [4] = '{3'h0, 3'h3, 3'h4, 3'h6};
  logic [7:0]  idx_tab [7] = '{STATUS_IDX, FRAME_IDX, IRQEN_IDX, BAUD_IDX, EXT_RX_IDX,
                               EXT_TX_IDX, 8'h56};
  logic [7:0]  rst_tab [7] = '{STATUS_RST, FRAME_RST, IRQEN_RST, BAUD_RST, EXT_RST,
                               EXT_RST, 8'h00};
  wire logic   line = tx_pin_oe ? tx_pin_out : 1'b1;  // released pin floats high

  always #5 sys_clk = ~sys_clk;

  async_serial_control_baud dut_u (.sys_clk(sys_clk), .reset(reset), .ce(1'b1), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(dat), .dat_o(dat_o),
    .ack_o(ack_o), .rx_pin(rx_pin), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
    .serial_irq(serial_irq));
  serial_node node_u (.sys_clk(sys_clk), .line_in(line), .bit_clks(bit_clks),
    .data_bits(nbits), .line_out(rx_pin), .got(got), .got_count(got_count));

  task automatic chk(input string what, input logic [8:0] x, input logic [8:0] s);
    num_checks++;
    if (s !== x)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, x, s);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one classic cycle; request held until ack is sampled, then dropped for a cycle
  task automatic wb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, wd};
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (ack_o !== 1'b1 && k < 20);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) chk("bus ack", 9'h001, 9'h000);
  endtask

  // data bits a frame must carry for a byte and {nine, parity on, odd}
  function automatic logic [8:0] exp_word(input logic [7:0] b, input logic [2:0] m,
                                          input logic t8);
    if (!m[2]) return {1'b0, m[1] ? {^b[6:0] ^ m[0], b[6:0]} : b};
    return {m[1] ? ^b ^ m[0] : t8, b};
  endfunction

  // poll status until the receive flag shows, bounded
  task automatic wait_rx();
    n = 0;
    do
    begin
      wb(1'b0, STATUS_IDX, 8'h00);
      n++;
    end
    while (q[RX_FULL_FLAG_POS] !== 1'b1 && n < 3000);
    chk("rx ready", 9'h001, {8'h00, q[RX_FULL_FLAG_POS]});
  endtask

  // status access then data write, wait for the node, then one bit time more, to mid stop bit
  task automatic tx_byte(input logic [7:0] b);
    int c;
    c = got_count;
    wb(1'b0, STATUS_IDX, 8'h00);
    wb(1'b1, DATA_IDX, b);
    n = 0;
    while (got_count == c && n < 20000)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("tx sent", 9'h001, {8'h00, got_count != c});
    repeat (bit_clks) @(posedge sys_clk);  // idle before any frame change
  endtask

  // watchdog sized well above the longest expected run
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    close_out();
  end

  initial
  begin
    d = $urandom(97);
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    for (i = 0; i < 7; i++)
    begin
      wb(1'b0, idx_tab[i], 8'h00);
      chk("reset value", {1'b0, rst_tab[i]}, {1'b0, i == 1 ? q & 8'h7f : q});
    end
    for (i = 3; i < 7; i++)
    begin
      d = $urandom;
      wb(1'b1, idx_tab[i], d);
      wb(1'b0, idx_tab[i], 8'h00);
      chk("read back", {1'b0, i == 6 ? 8'h00 : d}, {1'b0, q});
    end
    for (i = 0; i < 2; i++)
    begin
      wb(1'b1, IRQEN_IDX, 8'h80 >> i);
      repeat (2) @(posedge sys_clk);
      chk("irq on", 9'h001, {8'h00, serial_irq});
      wb(1'b1, IRQEN_IDX, 8'h00);
      repeat (2) @(posedge sys_clk);
      chk("irq off", 9'h000, {8'h00, serial_irq});
    end
    for (i = 0; i < 4; i++)
    begin
      t = $urandom % 2;
      e = i == 0 ? 8'h02 + ($urandom % 2) : 8'h00;
      bt = 16 * pr_tab[i] * (1 << t) * (e == 8'h00 ? 1 : e);
      bit_clks = bt[15:0];
      f = f_tab[i];
      nbits = f[2] ? 4'h9 : 4'h8;
      w[8] = $urandom;
      wb(1'b1, BAUD_IDX, {i[1:0], t, t});
      wb(1'b1, EXT_TX_IDX, e);
      wb(1'b1, EXT_RX_IDX, e);
      wb(1'b1, FRAME_IDX, {1'b0, w[8], 1'b0, f[2], 1'b0, f[1], f[0], 1'b0});
      wb(1'b1, IRQEN_IDX, 8'h0c);
      d = $urandom;
      tx_byte(d);
      chk("tx frame", exp_word(d, f, w[8]), got);
      w = exp_word($urandom, f, $urandom);
      node_u.send(w);
      wait_rx();
      chk("rx parity ok", 9'h000, {8'h00, q[PE_POS]});
      wb(1'b0, DATA_IDX, 8'h00);
      chk("rx data", {1'b0, w[7:0]}, {1'b0, q});
      wb(1'b0, FRAME_IDX, 8'h00);
      if (f[2]) chk("rx ninth", {8'h00, w[8]}, {8'h00, q[RX_NINTH_POS]});
    end
    bit_clks = 16'h0010;
    nbits = 4'h8;
    wb(1'b1, BAUD_IDX, 8'h00);
    wb(1'b1, EXT_TX_IDX, 8'h00);
    wb(1'b1, EXT_RX_IDX, 8'h00);
    wb(1'b1, FRAME_IDX, 8'h0d);
    d = $urandom;
    node_u.send({1'b0, ~^d[6:0], d[6:0]});
    wait_rx();
    chk("parity error", 9'h001, {8'h00, q[PE_POS]});
    chk("parity irq", 9'h001, {8'h00, serial_irq});
    wb(1'b0, DATA_IDX, 8'h00);
    wb(1'b1, IRQEN_IDX, 8'h0e);
    node_u.send(9'h055);
    node_u.send(9'h0a5);
    wait_rx();
    wb(1'b0, DATA_IDX, 8'h00);
    chk("wake word", 9'h0a5, {1'b0, q});
    wb(1'b1, IRQEN_IDX, 8'h0d);
    n = got_count;
    wb(1'b1, IRQEN_IDX, 8'h0c);
    for (i = 0; i < 2000 && got_count == n; i++) @(posedge sys_clk);
    chk("break sent", 9'h001, {8'h00, got_count != n});
    chk("break word", 9'h000, got);
    close_out();
  end
endmodule
`default_nettype wire
